/* fss_pkg.sv */
package fss_pkg;
   // command codes written in the third bus cycle
   localparam logic [7:0] FSS_CMD_SLEEP      = 8'hC0;
   localparam logic [7:0] FSS_CMD_ABORT      = 8'hE0;
   localparam logic [7:0] FSS_CMD_READ_ARRAY = 8'hF0;
   localparam logic [7:0] FSS_CMD_READ_STAT  = 8'h70;
   localparam logic [7:0] FSS_CMD_CLR_STAT   = 8'h50;
   // program and erase set-up codes, refused while their fail flag stands
   localparam logic [7:0] FSS_CMD_PROGRAM     = 8'hA0;
   localparam logic [7:0] FSS_CMD_ERASE_SETUP = 8'h80;
   // unlock cycles before each command
   localparam logic [15:0] FSS_UNLOCK_ADDR1  = 16'h5555;
   localparam logic [15:0] FSS_UNLOCK_ADDR2  = 16'h2AAA;
   localparam logic [7:0]  FSS_UNLOCK_DATA1  = 8'hAA;
   localparam logic [7:0]  FSS_UNLOCK_DATA2  = 8'h55;
   // status word bit positions
   localparam int FSS_BIT_READY   = 7;
   localparam int FSS_BIT_SUSPEND = 6;
   localparam int FSS_BIT_EFAIL   = 5;
   localparam int FSS_BIT_PFAIL   = 4;
   localparam int FSS_BIT_PROTECT = 3;
   localparam int FSS_BIT_SLEEP   = 2;
   localparam logic [7:0] FSS_STAT_MASK = 8'hFC;
   // wishbone register byte addresses
   localparam logic [3:0] FSS_REG_CTRL   = 4'h0;
   localparam logic [3:0] FSS_REG_STATUS = 4'h4;
   localparam logic [3:0] FSS_REG_INFO   = 4'h8;
   // control register fields
   localparam int FSS_CTRL_CMD_LSB = 0;
   localparam int FSS_CTRL_GO      = 8;
   // pin timing: low and high time of each strobe
   localparam int FSS_STROBE_NS     = 120;
   localparam int FSS_CLK_NS        = 4;
   localparam int FSS_STROBE_CYCLES = (FSS_STROBE_NS + FSS_CLK_NS - 1) / FSS_CLK_NS;
   localparam logic [7:0] FSS_CNT_W0 = 8'h00;
   // one bus cycle on the flash pins
   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  data;
   } fss_pin_req_t;
   typedef enum logic [1:0] {FSS_POLL, FSS_CMD1, FSS_CMD2, FSS_CMD3} fss_step_t;
endpackage

/* fss_pin_cycle.sv */
`timescale 1ns/1ns
`default_nettype none
module fss_pin_cycle
   import fss_pkg::*;
(
   input  wire logic         i_sys_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_start,
   input  wire fss_pin_req_t i_req,
   input  wire logic [15:0]  i_dq_in,
   output logic              o_busy,
   output logic              o_done,
   output logic [15:0]       o_rdata,
   output logic              o_ce_n,
   output logic              o_oe_n,
   output logic              o_we_n,
   output logic [15:0]       o_addr,
   output logic [15:0]       o_dq_out,
   output logic              o_dq_oe
);
   typedef enum logic [1:0] {PC_IDLE, PC_LOW, PC_HIGH} pc_state_t;
   pc_state_t   state_r;
   logic [7:0]  cnt_r;
   logic [15:0] dq_s1_r;
   logic [15:0] dq_s2_r;
   logic        wr_r;
   logic        cnt_end;
   assign cnt_end = (cnt_r == 8'(FSS_STROBE_CYCLES - 1));
   assign o_busy  = (state_r != PC_IDLE);

   // data pins pass two flops before use
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         dq_s1_r <= 16'h0000;
         dq_s2_r <= 16'h0000;
      end else begin
         dq_s1_r <= i_dq_in;
         dq_s2_r <= dq_s1_r;
      end
   end

   // strobe low phase then high phase; ce and oe both toggle per read
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_r  <= PC_IDLE;
         cnt_r    <= FSS_CNT_W0;
         wr_r     <= 1'b0;
         o_ce_n   <= 1'b1;
         o_oe_n   <= 1'b1;
         o_we_n   <= 1'b1;
         o_addr   <= 16'h0000;
         o_dq_out <= 16'h0000;
         o_dq_oe  <= 1'b0;
         o_done   <= 1'b0;
         o_rdata  <= 16'h0000;
      end else begin
         o_done <= 1'b0;
         case (state_r)
            PC_IDLE: begin
               if (i_start) begin
                  state_r  <= PC_LOW;
                  cnt_r    <= FSS_CNT_W0;
                  wr_r     <= i_req.wr;
                  o_addr   <= i_req.addr;
                  o_dq_out <= {8'h00, i_req.data};
                  o_dq_oe  <= i_req.wr;
                  o_ce_n   <= 1'b0;
                  o_oe_n   <= i_req.wr;
                  o_we_n   <= !i_req.wr;
               end
            end
            PC_LOW: begin
               cnt_r <= cnt_r + 8'h01;
               if (cnt_end) begin
                  state_r <= PC_HIGH;
                  cnt_r   <= FSS_CNT_W0;
                  o_ce_n  <= 1'b1;
                  o_oe_n  <= 1'b1;
                  o_we_n  <= 1'b1;
                  if (!wr_r) begin
                     o_rdata <= dq_s2_r;
                  end
               end
            end
            PC_HIGH: begin
               cnt_r <= cnt_r + 8'h01;
               if (cnt_end) begin
                  state_r <= PC_IDLE;
                  o_dq_oe <= 1'b0;
                  o_done  <= 1'b1;
               end
            end
            default: state_r <= PC_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

/* fss_host.sv */
`timescale 1ns/1ns
`default_nettype none
// What the host and the flash device must do
// RQ1 - device gives status on data 2..7, zeros elsewhere
// RQ2 - device latches status at later falling edge of oe or ce
// RQ3 - host toggles ce and oe for each status read
// RQ4 - sequencer sets bits 4..7, clears only 6 and 7
// RQ5 - fail flags stay set until clear-status command
// RQ6 - erase, program, read-status commands make reads return status
// RQ7 - after power-up or wake status bits 7..4 read 1000
// RQ8 - bit 3 shows sector protection only
// RQ9 - bit 2 set in sleep or abort, cleared by read-array
// RQ10 - no program or erase while its fail flag is set
// RQ11 - host issues a read command before read cycles
// RQ12 - sleep accepted anytime except after erase suspend
// RQ13 - sleep is three bus writes ending with C0
// RQ14 - sleep finishes operation, keeps status, stays read-status
// RQ15 - status and id reads stay valid during sleep
// RQ16 - read-array wakes device and clears bit 2
// RQ17 - three-cycle E0 abort stops operation, enters sleep
// RQ18 - abort sets program-fail or erase-fail
// RQ19 - abort acts only while program or erase runs
// RQ20 - bit 7 ready, bit 6 erase suspended
// RQ21 - bits 4 and 5 report program and erase failure
// RQ22 - host masks reserved bits 0 and 1
// RQ23 - after read-status all reads return status
// RQ24 - suspend sets bit 6 at once, bit 7 when suspended
// RQ25 - clear-status code is a configurable constant
module fss_host
   import fss_pkg::*;
#(
   parameter logic [7:0] CLR_STAT_CODE = FSS_CMD_CLR_STAT
)(
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [3:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic [31:0]      o_wb_dat,
   output logic             o_wb_ack,
   output logic             o_ce_n,
   output logic             o_oe_n,
   output logic             o_we_n,
   output logic [15:0]      o_addr,
   input  wire logic [15:0] i_dq,
   output logic [15:0]      o_dq,
   output logic             o_dq_oe
);
   fss_step_t    step_r;
   logic [7:0]   cmd_r;
   logic         pending_r;
   logic         auto_poll_r;
   logic [7:0]   status_r;
   logic         rs_mode_r;
   logic         start;
   logic         busy;
   logic         done;
   logic [15:0]  rdata;
   fss_pin_req_t req;
   logic         wb_hit;
   logic         go_wr;
   logic         cyc_wr_r;
   logic [7:0]   go_code;
   logic         retry_blk;

   // commands after which the flash answers reads with its status word
   function automatic logic status_follows(input logic [7:0] code);
      status_follows = (code != FSS_CMD_READ_ARRAY) && (code != CLR_STAT_CODE);
   endfunction

   // program or erase retry while its own fail flag still stands
   function automatic logic retry_refused(input logic [7:0] code, input logic [7:0] stat);
      retry_refused = (stat[FSS_BIT_PFAIL] && (code == FSS_CMD_PROGRAM))
                      || (stat[FSS_BIT_EFAIL] && (code == FSS_CMD_ERASE_SETUP));
   endfunction

   assign wb_hit = i_wb_cyc && i_wb_stb && !o_wb_ack;
   // code a go write would send: new byte if selected, else the held one
   assign go_code = i_wb_sel[0] ? i_wb_dat[FSS_CTRL_CMD_LSB +: 8] : cmd_r;
   // RQ10 retry refused on fail
   assign retry_blk = retry_refused(go_code, status_r);
   assign go_wr  = wb_hit && i_wb_we && (i_wb_adr == FSS_REG_CTRL) && i_wb_sel[1]
                   && i_wb_dat[FSS_CTRL_GO] && !pending_r
                   && !retry_blk;

   // wishbone slave: one wait cycle, ack for one cycle
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= wb_hit;
         o_wb_dat <= 32'h0000_0000;
         if (wb_hit && !i_wb_we) begin
            case (i_wb_adr)
               FSS_REG_CTRL:   o_wb_dat <= {23'h000000, pending_r, cmd_r};
               // reserved bits 0 and 1 masked from software view
               // RQ22 mask reserved bits
               FSS_REG_STATUS: o_wb_dat <= {24'h000000, status_r & FSS_STAT_MASK};
               FSS_REG_INFO:   o_wb_dat <= {30'h00000000, auto_poll_r, rs_mode_r};
               default:        o_wb_dat <= 32'h0000_0000;
            endcase
         end
      end
   end

   // command latch: software writes code and go bit
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cmd_r     <= FSS_CMD_READ_ARRAY;
         pending_r <= 1'b0;
      end else if (go_wr) begin
         if (i_wb_sel[0]) begin
            cmd_r <= i_wb_dat[FSS_CTRL_CMD_LSB +: 8];
         end
         pending_r <= 1'b1;
      end else if (done && step_r == FSS_CMD3) begin
         pending_r <= 1'b0;
      end
   end

   // sequence: idle polls status while auto_poll_r is set, a command takes three writes
   // RQ13 three-cycle command
   always_comb begin
      req  = '{wr: 1'b0, addr: 16'h0000, data: 8'h00};
      start = 1'b0;
      case (step_r)
         FSS_POLL: begin
            start = (pending_r || auto_poll_r) && !busy && !done;
            req.wr = pending_r;
            req.addr = FSS_UNLOCK_ADDR1;
            req.data = FSS_UNLOCK_DATA1;
         end
         FSS_CMD2: begin
            start = !busy && !done;
            req = '{wr: 1'b1, addr: FSS_UNLOCK_ADDR2, data: FSS_UNLOCK_DATA2};
         end
         FSS_CMD3: begin
            start = !busy && !done;
            req = '{wr: 1'b1, addr: FSS_UNLOCK_ADDR1, data: cmd_r};
         end
         default: begin
            start = 1'b0;
         end
      endcase
   end

   // step advance after each completed write pin cycle
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         step_r <= FSS_POLL;
      end else if (done) begin
         case (step_r)
            // only a finished write is the first unlock cycle, never a poll read
            FSS_POLL: step_r <= cyc_wr_r ? FSS_CMD2 : FSS_POLL;
            FSS_CMD2: step_r <= FSS_CMD3;
            FSS_CMD3: step_r <= FSS_POLL;
            default:  step_r <= FSS_POLL;
         endcase
      end
   end

   // device read mode: status reads follow status-producing commands
   // RQ11 read command first
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rs_mode_r   <= 1'b0;
         auto_poll_r <= 1'b0;
      end else if (done && step_r == FSS_CMD3) begin
         // RQ23 status mode persists
         // read-array and clear-status leave the device out of status reads
         rs_mode_r   <= status_follows(cmd_r);
         auto_poll_r <= status_follows(cmd_r);
      end
   end

   // status capture: each poll is its own ce/oe cycle
   // RQ3 toggled per read
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         status_r <= 8'h80;
      end else if (done && step_r == FSS_POLL && !cyc_wr_r) begin
         status_r <= rdata[7:0];
      // RQ5 fail flags cleared
      end else if (done && step_r == FSS_CMD3 && cmd_r == CLR_STAT_CODE) begin
         status_r[FSS_BIT_PFAIL] <= 1'b0;
         status_r[FSS_BIT_EFAIL] <= 1'b0;
      end
   end

   // direction of the pin cycle in flight; a poll read may still run when
   // software posts a command, and its end must not pass for an unlock write
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cyc_wr_r <= 1'b0;
      end else if (start) begin
         cyc_wr_r <= req.wr;
      end
   end

   fss_pin_cycle u_pin (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_start   (start),
      .i_req     (req),
      .i_dq_in   (i_dq),
      .o_busy    (busy),
      .o_done    (done),
      .o_rdata   (rdata),
      .o_ce_n    (o_ce_n),
      .o_oe_n    (o_oe_n),
      .o_we_n    (o_we_n),
      .o_addr    (o_addr),
      .o_dq_out  (o_dq),
      .o_dq_oe   (o_dq_oe)
   );
endmodule
`default_nettype wire

/* fss_host_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module fss_host_asserts
   import fss_pkg::*;
(
   input wire logic        i_sys_clk, i_resetn, i_wb_cyc, i_wb_stb, i_wb_we,
   input wire logic [3:0]  i_wb_adr, i_wb_sel,
   input wire logic [31:0] i_wb_dat, o_wb_dat,
   input wire logic        o_wb_ack, o_ce_n, o_oe_n, o_we_n, o_dq_oe,
   input wire logic [15:0] o_addr, i_dq, o_dq
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
   ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("request not acked next cycle");
   stat_mask_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == FSS_REG_STATUS |->
      o_wb_dat[1:0] == 2'h0) else $error("reserved status bits not masked");
   read_toggle_a: assert property ($fell(o_oe_n) |-> ##[1:40] $rose(o_oe_n))
      else $error("read strobe not toggled");
   wr_inhibit_a: assert property (!o_we_n |-> o_oe_n && !o_ce_n)
      else $error("write without chip enable or with output enable");
   bus_drive_a: assert property (!o_oe_n |-> !o_dq_oe) else $error("data driven during read");
   wr_stable_a: assert property (!o_we_n && $past(!o_we_n) |->
      $stable(o_dq) && $stable(o_addr)) else $error("write data moved in pulse");
   pulse_len_a: assert property ($fell(o_we_n) |-> !o_we_n [*8]) else $error("write pulse short");
   wr_pace_a: assert property ($rose(o_we_n) |-> o_we_n [*8]) else $error("write gap short");
endmodule
`default_nettype wire

/* fss_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fss_flash_model
   import fss_pkg::*;
#(parameter logic PROTECT = 1'b1, parameter logic [15:0] ARRAY = 16'h1234,
  parameter logic [7:0] SUSPEND = 8'h3C) // suspend code value is arbitrary
(
   input wire logic        i_ce_n, i_oe_n, i_we_n, i_run,
   input wire logic [15:0] i_addr, i_dq,
   output logic [15:0]     o_dq
);
   logic [1:0] step = 2'h0;
   logic       smode = 0, slp = 0, pf = 0, abt = 0, susp = 0;
   logic [7:0] lat = 8'h80;
   wire        busy = i_run && !abt && !susp;
   wire        rd = !i_ce_n && !i_oe_n;
   wire        wact = !i_ce_n && !i_we_n && i_oe_n;
   // decoder
   // a write is taken when its pulse ends, whichever of ce or we rises first
   always @(negedge wact) begin
      if (!i_run) {abt, susp} = 2'h0;
      if (step == 2'h0)
         step = (i_addr == FSS_UNLOCK_ADDR1 && i_dq[7:0] == FSS_UNLOCK_DATA1) ? 2'h1 : 2'h0;
      else if (step == 2'h1)
         step = (i_addr == FSS_UNLOCK_ADDR2 && i_dq[7:0] == FSS_UNLOCK_DATA2) ? 2'h2 : 2'h0;
      else begin
         step = 2'h0;
         case (i_dq[7:0])
            FSS_CMD_READ_STAT: smode = 1;
            FSS_CMD_READ_ARRAY: {smode, slp} = 2'h0;
            FSS_CMD_SLEEP: if (!susp) {smode, slp} = 2'h3;
            FSS_CMD_CLR_STAT: pf = 0;
            FSS_CMD_ABORT: if (busy) {abt, pf, slp, smode} = 4'hF;
            SUSPEND: if (busy) {susp, smode} = 2'h3;
            default: ;
         endcase
      end
   end
   always @(posedge rd) lat = {!busy, susp, 1'b0, pf, PROTECT, slp, 2'h0};
   // released bus shows inverse of last word
   assign o_dq = rd ? (smode ? {8'h00, lat} : ARRAY) : ~(smode ? {8'h00, lat} : ARRAY);
endmodule
`default_nettype wire

/* fss_host_test.sv */
`timescale 1ns/1ns
`default_nettype none
module fss_host_test;
   import fss_pkg::*;
   logic        i_sys_clk = 0, i_resetn = 0, cyc = 0, we = 0, chk = 0, run = 0;
   logic [3:0]  adr = 4'h0, ra;
   logic [31:0] wdat = 32'h0, rdat, o_wb_dat;
   logic        o_wb_ack, ce_n, oe_n, we_n, dq_oe;
   logic [15:0] fa, hdq, fdq;
   wire  [15:0] bus = dq_oe ? hdq : fdq;
   logic [31:0] expq[$];
   int          error_cnt = 0, checks = 0, i;
   always #2 i_sys_clk = ~i_sys_clk;
   fss_host dut(.i_sys_clk, .i_resetn, .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat, .o_wb_ack, .o_ce_n(ce_n),
      .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(fa), .i_dq(bus), .o_dq(hdq), .o_dq_oe(dq_oe));
   fss_flash_model mdl(.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_run(run),
      .i_addr(fa), .i_dq(bus), .o_dq(fdq));
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic c = 1'b0);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      cyc <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      chk <= c;
      do begin @(posedge i_sys_clk); n++; end while (o_wb_ack !== 1'b1 && n < 100);
      rdat = o_wb_dat;
      cyc <= 0;
      chk <= 0;
      if (n >= 100) begin error_cnt++; final_report(); end
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      expq.push_back(e);
      wb(0, a, 32'h0, 1'b1);
   endtask
   // command, wait for pending to drop, let a few polls land
   task automatic cmd(input logic [7:0] c);
      wb(1, FSS_REG_CTRL, {23'h0, 1'b1, c});
      do wb(0, FSS_REG_CTRL, 32'h0); while (rdat[FSS_CTRL_GO] !== 1'b0);
      repeat (200) @(posedge i_sys_clk);
   endtask
   task automatic cmp(input logic [3:0] a, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin error_cnt++; $display("[ERR] rdata@%h exp %h got %h", a, e, g); end
   endtask
   always @(posedge i_sys_clk) if (o_wb_ack === 1'b1 && chk) cmp(adr, expq.pop_front(), o_wb_dat);
   task automatic final_report();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin #200000; error_cnt++; final_report(); end
   initial begin
      i = $urandom(19);
      repeat (8) @(posedge i_sys_clk);
      i_resetn <= 1;
      rd(FSS_REG_STATUS, 32'h80);
      cmd(FSS_CMD_READ_STAT);
      rd(FSS_REG_STATUS, 32'h88);
      cmd(FSS_CMD_SLEEP);
      rd(FSS_REG_STATUS, 32'h8C);
      run <= 1;
      cmd(FSS_CMD_READ_STAT);
      rd(FSS_REG_STATUS, 32'h0C);
      cmd(FSS_CMD_ABORT);
      rd(FSS_REG_STATUS, 32'h9C);
      run <= 0;
      cmd(FSS_CMD_READ_STAT);
      rd(FSS_REG_STATUS, 32'h9C);
      wb(1, FSS_REG_CTRL, {23'h0, 1'b1, FSS_CMD_PROGRAM});
      rd(FSS_REG_CTRL, {23'h0, 1'b0, FSS_CMD_READ_STAT});
      cmd(FSS_CMD_CLR_STAT);
      rd(FSS_REG_STATUS, 32'h8C);
      rd(FSS_REG_INFO, 32'h0);
      cmd(FSS_CMD_READ_STAT);
      rd(FSS_REG_STATUS, 32'h8C);
      cmd(FSS_CMD_READ_ARRAY);
      cmd(FSS_CMD_READ_STAT);
      rd(FSS_REG_STATUS, 32'h88);
      rd(FSS_REG_INFO, 32'h3);
      cmd(FSS_CMD_ABORT);
      rd(FSS_REG_STATUS, 32'h88);
      for (i = 0; i < 4; i++) begin
         ra = 4'hC | 4'($urandom & 3);
         wb(1, ra, $urandom);
         rd(ra, 32'h0);
      end
      rd(FSS_REG_STATUS, 32'h88);
      final_report();
   end
endmodule
bind fss_host fss_host_asserts chk_i(.i_sys_clk, .i_resetn, .i_wb_cyc, .i_wb_stb, .i_wb_we,
   .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_ce_n, .o_oe_n, .o_we_n,
   .o_dq_oe, .o_addr, .i_dq, .o_dq);
`default_nettype wire
